/* File: hw/gpio_irq_pkg.sv */
// Purpose: shared constants for the eight-terminal pin interrupt block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses, one word per register
// Notes:   only the low eight bits of every register carry data

package gpio_irq_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned PINS   = 8;
  localparam int unsigned ADDR_W = 8;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_OUT_DATA   = 8'h08;
  localparam logic [7:0] OFF_IN_DATA    = 8'h0c;
  localparam logic [7:0] OFF_EVT_ENABLE = 8'h10;
  localparam logic [7:0] OFF_RAW_EVT    = 8'h14;
  localparam logic [7:0] OFF_MASKED_EVT = 8'h18;
  localparam logic [7:0] OFF_EVT_CLEAR  = 8'h1c;
  localparam logic [7:0] OFF_TRIG_TYPE  = 8'h20;
  localparam logic [7:0] OFF_TRIG_POL   = 8'h24;
  localparam logic [7:0] OFF_BOTH_EDGE  = 8'h28;
  localparam logic [7:0] OFF_OUT_SET    = 8'h2c;
  localparam logic [7:0] OFF_OUT_CLEAR  = 8'h30;

  // ----------------------------------------------------------------
  // reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;

endpackage

/* File: hw/pin_event_detect.sv */
// Purpose: synchronise eight pins and detect level or edge trigger conditions
// Assumes: pins are asynchronous to aclk
// Notes:   event_o is a per-cycle condition; the caller holds it as a sticky flag

`timescale 1ns/1ps

module pin_event_detect (
  input  logic       aclk,     // bus clock
  input  logic       aresetn,  // synchronous reset, active low
  input  logic [7:0] pin_i,    // raw pin levels
  input  logic [7:0] type_i,   // 0 edge, 1 level
  input  logic [7:0] pol_i,    // 0 low/falling, 1 high/rising
  input  logic [7:0] any_i,    // 1 both edges
  output logic [7:0] sync_o,   // synchronised pin levels
  output logic [7:0] event_o   // trigger condition this cycle
);

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] prev;
  } det_s;

  det_s q;
  det_s d;

  // ----------------------------------------------------------------
  // synchroniser and history
  // ----------------------------------------------------------------
  always_comb begin
    d      = q;
    d.s1   = pin_i;
    d.s2   = q.s1;
    d.prev = q.s2;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.s2;

  // ----------------------------------------------------------------
  // trigger condition
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (type_i[i]) begin
        event_o[i] = ~(q.s2[i] ^ pol_i[i]);
      end else if (any_i[i]) begin
        event_o[i] = q.s2[i] ^ q.prev[i];
      end else begin
        event_o[i] = pol_i[i] ? (q.s2[i] & ~q.prev[i]) : (~q.s2[i] & q.prev[i]);
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_both_edges;
    @(posedge aclk) disable iff (!aresetn)
    1 |=> ((any_i & ~type_i & (sync_o ^ $past(sync_o)) & ~event_o) == 8'h00);
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("both-edge change missed");

  property p_level_match;
    @(posedge aclk) disable iff (!aresetn)
    ((type_i & (sync_o ^ pol_i) & event_o) == 8'h00);
  endproperty
  a_level_match: assert property (p_level_match) else $error("level event at inactive level");

endmodule

/* File: hw/gpio_pin_interrupt_logic.sv */
// Purpose: pin interrupt and atomic output-set logic of one eight-terminal port
// Assumes: AXI4-Lite master keeps one write and one read outstanding
// Notes:   irq is a level, high while any enabled raw flag is set
//
// Decided for this implementation: the AXI4-Lite interface to the registers.

`timescale 1ns/1ps

module gpio_pin_interrupt_logic (
  input  logic        aclk,      // bus clock, 25 MHz
  input  logic        aresetn,   // synchronous reset, active low
  input  logic [7:0]  awaddr,    // write address
  input  logic        awvalid,   // write address valid
  output logic        awready,   // write address ready
  input  logic [31:0] wdata,     // write data
  input  logic [3:0]  wstrb,     // write byte strobes
  input  logic        wvalid,    // write data valid
  output logic        wready,    // write data ready
  output logic [1:0]  bresp,     // write response
  output logic        bvalid,    // write response valid
  input  logic        bready,    // write response ready
  input  logic [7:0]  araddr,    // read address
  input  logic        arvalid,   // read address valid
  output logic        arready,   // read address ready
  output logic [31:0] rdata,     // read data
  output logic [1:0]  rresp,     // read response
  output logic        rvalid,    // read data valid
  input  logic        rready,    // read data ready
  input  logic [7:0]  pin_i,     // terminal input levels
  output logic [7:0]  out_data,  // output data register
  output logic        irq        // port interrupt, level
);

  typedef struct packed {
    logic        aw_full;
    logic [7:0]  aw_addr;
    logic        w_full;
    logic [7:0]  w_data;
    logic        w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  en;
    logic [7:0]  raw;
    logic [7:0]  typ;
    logic [7:0]  pol;
    logic [7:0]  any;
    logic [7:0]  odr;
  } regs_s;

  regs_s q;
  regs_s d;

  logic [7:0] pin_sync;
  logic [7:0] pin_event;
  logic       aw_ok;
  logic       w_ok;
  logic       do_wr;
  logic [7:0] wr_addr;
  logic [7:0] wr_byte;
  logic [7:0] clr_mask;
  logic [7:0] set_mask;
  logic [7:0] oclr_mask;
  logic [7:0] masked;

  // ----------------------------------------------------------------
  // pin synchroniser and trigger detection
  // ----------------------------------------------------------------
  pin_event_detect u_detect (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_i   (pin_i),
    .type_i  (q.typ),
    .pol_i   (q.pol),
    .any_i   (q.any),
    .sync_o  (pin_sync),
    .event_o (pin_event)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // returns {error, word}; write-only registers read as zero
  function automatic logic [32:0] rd_word(input logic [7:0] a, input regs_s r,
                                          input logic [7:0] syn);
    logic [7:0] v;
    logic       err;
    v   = gpio_irq_pkg::RST_BYTE;
    err = 1'b0;
    if (hit(a, gpio_irq_pkg::OFF_OUT_DATA)) begin
      v = r.odr;
    end else if (hit(a, gpio_irq_pkg::OFF_IN_DATA)) begin
      v = syn;
    end else if (hit(a, gpio_irq_pkg::OFF_EVT_ENABLE)) begin
      v = r.en;
    end else if (hit(a, gpio_irq_pkg::OFF_RAW_EVT)) begin
      v = r.raw;
    end else if (hit(a, gpio_irq_pkg::OFF_MASKED_EVT)) begin
      v = r.raw & r.en;
    end else if (hit(a, gpio_irq_pkg::OFF_TRIG_TYPE)) begin
      v = r.typ;
    end else if (hit(a, gpio_irq_pkg::OFF_TRIG_POL)) begin
      v = r.pol;
    end else if (hit(a, gpio_irq_pkg::OFF_BOTH_EDGE)) begin
      v = r.any;
    end else if (!(hit(a, gpio_irq_pkg::OFF_EVT_CLEAR) || hit(a, gpio_irq_pkg::OFF_OUT_SET)
                   || hit(a, gpio_irq_pkg::OFF_OUT_CLEAR))) begin
      err = 1'b1;
    end
    return {err, 24'h00_0000, v};
  endfunction

  // ----------------------------------------------------------------
  // write path: address and data may arrive in either order
  // ----------------------------------------------------------------
  assign awready = !q.aw_full;
  assign wready  = !q.w_full;
  assign aw_ok   = q.aw_full | awvalid;
  assign w_ok    = q.w_full | wvalid;
  assign do_wr   = aw_ok & w_ok & !q.bvalid;
  assign wr_addr = q.aw_full ? q.aw_addr : awaddr;
  assign wr_byte = (q.w_full ? q.w_strb : wstrb[0]) ? (q.w_full ? q.w_data : wdata[7:0]) : 8'h00;

  // write-one strobes; all zero outside a committing write
  assign clr_mask  = (do_wr && hit(wr_addr, gpio_irq_pkg::OFF_EVT_CLEAR)) ? wr_byte : 8'h00;
  assign set_mask  = (do_wr && hit(wr_addr, gpio_irq_pkg::OFF_OUT_SET)) ? wr_byte : 8'h00;
  assign oclr_mask = (do_wr && hit(wr_addr, gpio_irq_pkg::OFF_OUT_CLEAR)) ? wr_byte : 8'h00;
  assign masked    = q.raw & q.en;

  always_comb begin
    logic [32:0] rd;
    logic [32:0] wr_chk;
    rd     = rd_word(araddr, q, pin_sync);
    wr_chk = rd_word(wr_addr, q, pin_sync);
    d      = q;

    if (do_wr) begin
      d.aw_full = 1'b0;
      d.w_full  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = wr_chk[32] ? gpio_irq_pkg::RESP_SLV : gpio_irq_pkg::RESP_OKAY;
      // byte lane 0 only carries data; a write without it changes nothing
      if (q.w_full ? q.w_strb : wstrb[0]) begin
        if (hit(wr_addr, gpio_irq_pkg::OFF_EVT_ENABLE)) d.en  = wr_byte;
        if (hit(wr_addr, gpio_irq_pkg::OFF_TRIG_TYPE))  d.typ = wr_byte;
        if (hit(wr_addr, gpio_irq_pkg::OFF_TRIG_POL))   d.pol = wr_byte;
        if (hit(wr_addr, gpio_irq_pkg::OFF_BOTH_EDGE))  d.any = wr_byte;
        if (hit(wr_addr, gpio_irq_pkg::OFF_OUT_DATA))   d.odr = wr_byte;
      end
    end else begin
      if (awvalid && !q.aw_full) begin
        d.aw_full = 1'b1;
        d.aw_addr = awaddr;
      end
      if (wvalid && !q.w_full) begin
        d.w_full = 1'b1;
        d.w_data = wdata[7:0];
        d.w_strb = wstrb[0];
      end
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end

    // masked status register ignores writes: no state is behind it
    d.raw = (q.raw & ~clr_mask) | pin_event;
    if (!(do_wr && hit(wr_addr, gpio_irq_pkg::OFF_OUT_DATA))) begin
      d.odr = (q.odr & ~oclr_mask) | set_mask;
    end

    // read path: one outstanding read, answered the cycle after it is taken
    if (arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata  = rd[31:0];
      d.rresp  = rd[32] ? gpio_irq_pkg::RESP_SLV : gpio_irq_pkg::RESP_OKAY;
    end else if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q      <= '0;
      q.en   <= gpio_irq_pkg::RST_BYTE;
      q.typ  <= gpio_irq_pkg::RST_BYTE;
      q.pol  <= gpio_irq_pkg::RST_BYTE;
      q.any  <= gpio_irq_pkg::RST_BYTE;
      q.raw  <= gpio_irq_pkg::RST_BYTE;
      q.odr  <= gpio_irq_pkg::RST_BYTE;
      q.rdata <= gpio_irq_pkg::RST_WORD;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign arready  = !q.rvalid;
  assign bvalid   = q.bvalid;
  assign bresp    = q.bresp;
  assign rvalid   = q.rvalid;
  assign rdata    = q.rdata;
  assign rresp    = q.rresp;
  assign out_data = q.odr;
  assign irq      = |masked;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_raw_sticky;
    @(posedge aclk) disable iff (!aresetn)
    1 |=> ((($past(q.raw) & ~$past(clr_mask)) & ~q.raw) == 8'h00);
  endproperty
  a_raw_sticky: assert property (p_raw_sticky) else $error("raw flag lost without clear");

  property p_masked_read;
    @(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && hit(araddr, gpio_irq_pkg::OFF_MASKED_EVT)) |=>
      (rvalid && rdata == {24'h00_0000, $past(masked)});
  endproperty
  a_masked_read: assert property (p_masked_read) else $error("masked read mismatch");

  property p_masked_ro;
    @(posedge aclk) disable iff (!aresetn)
    (do_wr && hit(wr_addr, gpio_irq_pkg::OFF_MASKED_EVT)) |=>
      ($stable(q.en) && $stable(q.odr) && $stable(q.typ) && bresp == gpio_irq_pkg::RESP_OKAY);
  endproperty
  a_masked_ro: assert property (p_masked_ro) else $error("write to masked status had effect");

  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
    (do_wr && hit(wr_addr, gpio_irq_pkg::OFF_EVT_CLEAR)) |=>
      ((q.raw & $past(clr_mask) & ~$past(pin_event)) == 8'h00);
  endproperty
  a_clear: assert property (p_clear) else $error("event clear failed");

  property p_level_sets;
    @(posedge aclk) disable iff (!aresetn)
    1 |=> ((($past(q.typ) & ~($past(pin_sync) ^ $past(q.pol))) & ~q.raw) == 8'h00);
  endproperty
  a_level_sets: assert property (p_level_sets) else $error("level condition not flagged");

  property p_out_set;
    @(posedge aclk) disable iff (!aresetn)
    (do_wr && hit(wr_addr, gpio_irq_pkg::OFF_OUT_SET)) |=>
      (((out_data & $past(set_mask)) == $past(set_mask)) && ((out_data ^ $past(out_data)) & ~$past(set_mask)) == 8'h00);
  endproperty
  a_out_set: assert property (p_out_set) else $error("output set wrong");

  property p_out_clr;
    @(posedge aclk) disable iff (!aresetn)
    (do_wr && hit(wr_addr, gpio_irq_pkg::OFF_OUT_CLEAR)) |=> ((out_data & $past(oclr_mask)) == 8'h00);
  endproperty
  a_out_clr: assert property (p_out_clr) else $error("output clear wrong");

  property p_reset_vals;
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (q.typ == 8'h00 && q.pol == 8'h00 && q.any == 8'h00 && q.raw == 8'h00 && !irq);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");

  property p_irq_gate;
    @(posedge aclk) disable iff (!aresetn)
    (q.en == 8'h00) |-> (!irq ##1 ((q.en != 8'h00) || !irq));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not masked");

  property p_write_resp;
    @(posedge aclk) disable iff (!aresetn)
    do_wr |=> (bvalid && !awready && !wready) or (bvalid);
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write not answered next cycle");

  property p_event_sets;
    @(posedge aclk) disable iff (!aresetn)
    1 |=> (($past(pin_event) & ~q.raw) == 8'h00);
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event lost or beaten by clear");

  property p_clear_keep;
    @(posedge aclk) disable iff (!aresetn)
    (do_wr && hit(wr_addr, gpio_irq_pkg::OFF_EVT_CLEAR)) |=>
      (($past(q.raw) & ~$past(wr_byte) & ~q.raw) == 8'h00);
  endproperty
  a_clear_keep: assert property (p_clear_keep) else $error("zero clear bit dropped a flag");

  property p_read_answer;
    @(posedge aclk) disable iff (!aresetn)
    (arvalid && arready) |=> (rvalid && !arready);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered next cycle");

endmodule

/* File: verif/pin_board_model.sv */
// Purpose: board-side stand-in that drives the eight terminal pins
// Assumes: the bench sets the wanted level of every pin
// Notes:   pins move a skew after the command, away from the sampling edge

`timescale 1ns/1ps

module pin_board_model #(
  parameter int SKEW_NS = 3
) (
  input  logic [7:0] level_cmd,  // wanted pin levels
  output logic [7:0] pin_level   // levels seen at the terminals
);
  // real pins are asynchronous, so they never change on the clock edge
  assign #(SKEW_NS) pin_level = level_cmd;
endmodule

/* File: verif/gpio_pin_interrupt_logic_tb_top.sv */
// Purpose: register-level tests of the pin interrupt and output-set logic
// Assumes: AXI4-Lite master with one transfer outstanding, 25 MHz clock
// Notes:   a two-way set and clear in one access cannot be made over this bus

`timescale 1ns/1ps

module gpio_pin_interrupt_logic_tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr, pin_i, out_data, level_cmd;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          n_mismatch, n_compared;
  localparam logic [7:0] a_out = gpio_irq_pkg::OFF_OUT_DATA;
  localparam logic [7:0] a_en  = gpio_irq_pkg::OFF_EVT_ENABLE;
  localparam logic [7:0] a_raw = gpio_irq_pkg::OFF_RAW_EVT;
  localparam logic [7:0] a_msk = gpio_irq_pkg::OFF_MASKED_EVT;
  localparam logic [7:0] a_clr = gpio_irq_pkg::OFF_EVT_CLEAR;
  localparam logic [7:0] a_typ = gpio_irq_pkg::OFF_TRIG_TYPE;
  localparam logic [7:0] a_pol = gpio_irq_pkg::OFF_TRIG_POL;
  localparam logic [7:0] a_any = gpio_irq_pkg::OFF_BOTH_EDGE;
  localparam logic [7:0] a_set = gpio_irq_pkg::OFF_OUT_SET;
  localparam logic [7:0] rst_addr [7] = '{a_out, a_en, a_raw, a_msk, a_typ, a_pol, a_any};

  gpio_pin_interrupt_logic gpio_pin_interrupt_logic_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pin_i(pin_i),
    .out_data(out_data), .irq(irq)
  );

  pin_board_model pin_board_model_i (
    .level_cmd(level_cmd),
    .pin_level(pin_i)
  );

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic timeout(input string what);
    n_mismatch++;
    $display("[ERR] %0t %s never answered", $time, what);
    give_verdict();
  endtask

  // ----------------------------------------------------------------
  // bus cycles: entered just after a rising edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] addr, input logic [31:0] data,
                    input logic [1:0] er = gpio_irq_pkg::RESP_OKAY);
    int n;
    logic aw_go, w_go, b_go;
    logic [1:0] resp;
    awaddr  <= addr;
    awvalid <= 1'b1;
    wdata   <= data;
    wstrb   <= 4'h1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // ready is decided by registered state, so the falling edge shows what the next edge takes
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      aw_go = awvalid & awready;
      w_go  = wvalid & wready;
      b_go  = bvalid & bready;
      resp  = bresp;
      @(posedge aclk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
      if (b_go) break;
    end
    if (n == 50) timeout("write");
    bready <= 1'b0;
    cmp({32'h0, resp}, {32'h0, er}, "write response");
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp,
                        input logic [1:0] er = gpio_irq_pkg::RESP_OKAY);
    int n;
    logic ar_go, r_go;
    logic [31:0] data;
    logic [1:0] resp;
    araddr  <= addr;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ar_go = arvalid & arready;
      r_go  = rvalid & rready;
      data  = rdata;
      resp  = rresp;
      @(posedge aclk);
      if (ar_go) arvalid <= 1'b0;
      if (r_go) break;
    end
    if (n == 50) timeout("read");
    rready <= 1'b0;
    cmp({resp, data}, {er, exp}, "read");
    @(posedge aclk);
  endtask

  task automatic chk_irq(input logic e);
    @(negedge aclk);
    cmp({33'h0, irq}, {33'h0, e}, "irq");
    @(posedge aclk);
  endtask

  task automatic chk_out(input logic [7:0] e);
    @(negedge aclk);
    cmp({26'h0, out_data}, {26'h0, e}, "out_data");
    @(posedge aclk);
  endtask

  // two sync flops plus the edge compare take three edges; six leaves margin
  task automatic pin_set(input logic [7:0] v);
    level_cmd <= v;
    repeat (6) @(posedge aclk);
  endtask

  task automatic end_test(input string name);
    $display("test %s finished, mismatches so far %0d", name, n_mismatch);
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    timeout("sequence");
  end

  initial begin
    n_mismatch = 0;
    n_compared = 0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    level_cmd = 8'hff;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rst_addr[i]) rd_chk(rst_addr[i], 32'h0);
    rd_chk(gpio_irq_pkg::OFF_IN_DATA, 32'hff);
    chk_irq(1'b0);
    end_test("reset values");
    pin_set(8'hfe);
    rd_chk(gpio_irq_pkg::OFF_IN_DATA, 32'hfe);
    rd_chk(a_raw, 32'h1);
    rd_chk(a_msk, 32'h0);
    chk_irq(1'b0);
    pin_set(8'hff);
    rd_chk(a_raw, 32'h1);
    wr(a_en, 32'h1);
    rd_chk(a_msk, 32'h1);
    chk_irq(1'b1);
    wr(a_msk, 32'h0);
    rd_chk(a_msk, 32'h1);
    wr(a_clr, 32'h0);
    rd_chk(a_raw, 32'h1);
    rd_chk(a_clr, 32'h0);
    wr(a_clr, 32'h1);
    rd_chk(a_raw, 32'h0);
    chk_irq(1'b0);
    end_test("falling edge and clear");
    wr(a_pol, 32'h2);
    rd_chk(a_pol, 32'h2);
    pin_set(8'hfd);
    rd_chk(a_raw, 32'h0);
    pin_set(8'hff);
    rd_chk(a_raw, 32'h2);
    wr(a_clr, 32'h2);
    wr(a_any, 32'h4);
    rd_chk(a_any, 32'h4);
    pin_set(8'hfb);
    rd_chk(a_raw, 32'h4);
    wr(a_clr, 32'h4);
    pin_set(8'hff);
    rd_chk(a_raw, 32'h4);
    wr(a_clr, 32'h4);
    rd_chk(a_raw, 32'h0);
    end_test("rising and both edges");
    wr(a_typ, 32'h8);
    rd_chk(a_typ, 32'h8);
    pin_set(8'hf7);
    rd_chk(a_raw, 32'h8);
    wr(a_clr, 32'h8);
    rd_chk(a_raw, 32'h8);
    wr(a_en, 32'h8);
    chk_irq(1'b1);
    pin_set(8'hff);
    wr(a_clr, 32'h8);
    rd_chk(a_raw, 32'h0);
    chk_irq(1'b0);
    end_test("level trigger");
    wr(a_out, 32'h0f);
    wr(a_set, 32'hf0);
    chk_out(8'hff);
    wr(a_set, 32'h00);
    chk_out(8'hff);
    rd_chk(a_set, 32'h0);
    wr(gpio_irq_pkg::OFF_OUT_CLEAR, 32'h0f);
    rd_chk(a_out, 32'hf0);
    wr(8'h40, 32'h1, gpio_irq_pkg::RESP_SLV);
    rd_chk(8'h40, 32'h0, gpio_irq_pkg::RESP_SLV);
    end_test("output set and unmapped");
    give_verdict();
  end
endmodule
